/* hdl/prsr_core.sv */
// Execution unit for the counter and status reads and the variable rotate.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Opcode 156 returns destination counter, slot 3.
// - Every interruptible jump loads destination counter.
// - Destination counter holds resume address when interrupted.
// - Opcode 158 returns whole status word, slot 3.
// - Status word holds mode and event fields.
// - Opcode 157 returns source counter, slot 3.
// - Source counter loads only without pending events.
// - Rotate 97 uses second source bits 4..0.
// - Destination is first source rotated left n.
// - Guard bit 0 low leaves destination unchanged.
module prsr_core
	import prsr_pkg::*;
(
	input  wire logic                      sys_clk_in,
	input  wire logic                      rst_n_in,
	input  wire prsr_issue_t               issue_in,
	input  wire prsr_jump_t                jump_in,
	input  wire logic                      mode_load_in,
	input  wire logic [PRSR_FIELD_W-1:0]   mode_value_in,
	input  wire logic [PRSR_FIELD_W-1:0]   event_set_in,
	input  wire logic [PRSR_FIELD_W-1:0]   event_clr_in,
	output var prsr_result_t               result_out,
	output logic                           illegal_slot_out,
	output logic [PRSR_DATA_W-1:0]         destination_program_counter_out,
	output logic [PRSR_DATA_W-1:0]         source_program_counter_out,
	output logic [PRSR_DATA_W-1:0]         control_status_word_out
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [PRSR_DATA_W-1:0]  dpc_r;
	logic [PRSR_DATA_W-1:0]  spc_r;
	logic [PRSR_FIELD_W-1:0] mode_r;
	logic [PRSR_FIELD_W-1:0] evt_r;
	prsr_result_t            result_r;
	logic                    illegal_r;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Opcode and slot decode; an op of ours in a wrong slot never writes.
	logic is_dpc_w;
	logic is_spc_w;
	logic is_csw_w;
	logic is_rol_w;
	logic slot_cmp_w;
	logic slot_shf_w;
	logic ours_w;
	logic legal_w;
	logic guard_ok_w;
	logic wr_nxt;

	assign is_dpc_w   = issue_in.valid && (issue_in.opcode == PRSR_OP_RD_DPC);
	assign is_spc_w   = issue_in.valid && (issue_in.opcode == PRSR_OP_RD_SPC);
	assign is_csw_w   = issue_in.valid && (issue_in.opcode == PRSR_OP_RD_CSW);
	assign is_rol_w   = issue_in.valid && (issue_in.opcode == PRSR_OP_ROL);
	assign slot_cmp_w = (issue_in.slot == PRSR_SLOT_CMP);
	assign slot_shf_w = (issue_in.slot == PRSR_SLOT_SHA) ||
	                    (issue_in.slot == PRSR_SLOT_SHB);
	assign ours_w     = is_dpc_w || is_spc_w || is_csw_w || is_rol_w;
	assign legal_w    = ((is_dpc_w || is_spc_w || is_csw_w) && slot_cmp_w) ||
	                    (is_rol_w && slot_shf_w);
	// A missing guard counts as true; a present one is judged on bit 0 only.
	assign guard_ok_w = !issue_in.has_guard || issue_in.guard[0];
	assign wr_nxt     = legal_w && guard_ok_w;

	// ----------------------------------------------------------------
	// Rotate path
	// ----------------------------------------------------------------
	// Only the low five bits of the amount reach the rotator.
	logic [PRSR_AMT_W-1:0]  rot_amt_w;
	logic [PRSR_DATA_W-1:0] rot_w;
	assign rot_amt_w = issue_in.second_source[PRSR_AMT_W-1:0];

	prsr_rotator #(
		.W     (PRSR_DATA_W),
		.AMT_W (PRSR_AMT_W)
	) u_rotator (
		.value_in    (issue_in.first_source),
		.amount_in   (rot_amt_w),
		.rotated_out (rot_w)
	);

	// ----------------------------------------------------------------
	// Result select
	// ----------------------------------------------------------------
	// Reads see the counters as they stand before any same-cycle jump.
	logic [PRSR_DATA_W-1:0] csw_w;
	logic [PRSR_DATA_W-1:0] data_nxt;
	assign csw_w    = {mode_r, evt_r};
	assign data_nxt = is_dpc_w ? dpc_r :
	                  is_spc_w ? spc_r :
	                  is_csw_w ? csw_w :
	                  rot_w;

	// Result register gives the one-cycle latency of all four operations.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			result_r  <= '0;
			illegal_r <= 1'b0;
		end else begin
			result_r.wr_en <= wr_nxt;
			result_r.dest  <= issue_in.dest;
			result_r.data  <= wr_nxt ? data_nxt : result_r.data;
			illegal_r      <= ours_w && !legal_w;
		end
	end

	// ----------------------------------------------------------------
	// Program counters
	// ----------------------------------------------------------------
	// The destination counter always takes the jump target, so an
	// interrupt taken at the jump resumes at that target.
	logic pend_w;
	assign pend_w = jump_in.nmi_pending || jump_in.int_pending ||
	                jump_in.exception_event;

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dpc_r <= PRSR_DPC_RST;
			spc_r <= PRSR_SPC_RST;
		end else if (jump_in.valid) begin
			dpc_r <= jump_in.target;
			if (!pend_w) begin
				spc_r <= jump_in.target;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status word
	// ----------------------------------------------------------------
	// Event bits are sticky; a set in the clearing cycle wins.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_r <= PRSR_MODE_RST;
			evt_r  <= PRSR_EVT_RST;
		end else begin
			if (mode_load_in) begin
				mode_r <= mode_value_in;
			end
			evt_r <= (evt_r & ~event_clr_in) | event_set_in;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign result_out                      = result_r;
	assign illegal_slot_out                = illegal_r;
	assign destination_program_counter_out = dpc_r;
	assign source_program_counter_out      = spc_r;
	assign control_status_word_out         = csw_w;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_rd_dpc_value: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(is_dpc_w && slot_cmp_w && guard_ok_w) |=>
			(result_out.wr_en && result_out.data == $past(dpc_r)))
		else $error("destination counter read returned wrong value");

	a_dpc_jump_load: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		jump_in.valid |=> (destination_program_counter_out == $past(jump_in.target)))
		else $error("destination counter missed jump target");

	a_rd_csw_value: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(is_csw_w && slot_cmp_w && guard_ok_w) |=>
			(result_out.wr_en && result_out.data == $past(control_status_word_out)))
		else $error("status word read returned wrong value");

	a_evt_sticky_set: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(event_set_in != 16'h0000) |=>
			((control_status_word_out[15:0] & $past(event_set_in)) == $past(event_set_in)))
		else $error("event bit not recorded");

	a_rd_spc_value: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(is_spc_w && slot_cmp_w && guard_ok_w) |=>
			(result_out.wr_en && result_out.data == $past(spc_r)))
		else $error("source counter read returned wrong value");

	a_spc_pend_hold: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(jump_in.valid && pend_w) |=> $stable(source_program_counter_out))
		else $error("source counter loaded while event pending");

	a_spc_clean_load: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(jump_in.valid && !pend_w) |=> (source_program_counter_out == $past(jump_in.target)))
		else $error("source counter missed clean jump target");

	a_rol_value: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(is_rol_w && slot_shf_w && guard_ok_w) |=> (result_out.wr_en &&
			result_out.data == (($past(issue_in.first_source) <<
				$past(issue_in.second_source[4:0])) |
			($past(issue_in.first_source) >> (6'd32 - {1'b0,
				$past(issue_in.second_source[4:0])}))))) 
		else $error("rotate result wrong");

	a_guard_false: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(issue_in.has_guard && !issue_in.guard[0]) |=>
			(!result_out.wr_en && $stable(result_out.data)))
		else $error("write despite false guard");

	a_no_guard_wr: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(legal_w && !issue_in.has_guard) |=> result_out.wr_en)
		else $error("unguarded operation did not write");

	a_rol_zero: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(is_rol_w && slot_shf_w && guard_ok_w && rot_amt_w == 5'h00) |=>
			(result_out.data == $past(issue_in.first_source)))
		else $error("zero rotate altered value");

endmodule : prsr_core
`default_nettype wire

/* hdl/prsr_pkg.sv */
// Shared constants and carrier types for the status read and rotate unit.
package prsr_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned PRSR_DATA_W  = 32;
	localparam int unsigned PRSR_AMT_W   = 5;
	localparam int unsigned PRSR_DEST_W  = 7;
	localparam int unsigned PRSR_FIELD_W = 16;

	// ----------------------------------------------------------------
	// Operation codes and issue slots
	// ----------------------------------------------------------------
	localparam logic [7:0] PRSR_OP_RD_DPC = 8'h9c; // Decimal 156.
	localparam logic [7:0] PRSR_OP_RD_SPC = 8'h9d; // Decimal 157.
	localparam logic [7:0] PRSR_OP_RD_CSW = 8'h9e; // Decimal 158.
	localparam logic [7:0] PRSR_OP_ROL    = 8'h61; // Decimal 97.
	localparam logic [2:0] PRSR_SLOT_CMP  = 3'h3;
	localparam logic [2:0] PRSR_SLOT_SHA  = 3'h1;
	localparam logic [2:0] PRSR_SLOT_SHB  = 3'h2;

	// ----------------------------------------------------------------
	// Status word layout, reset values and latency
	// ----------------------------------------------------------------
	localparam int unsigned PRSR_CSW_EVT_LSB  = 0;
	localparam int unsigned PRSR_CSW_MODE_LSB = 16;
	localparam logic [31:0] PRSR_DPC_RST      = 32'h0000_0000;
	localparam logic [31:0] PRSR_SPC_RST      = 32'h0000_0000;
	localparam logic [15:0] PRSR_MODE_RST     = 16'h0000;
	localparam logic [15:0] PRSR_EVT_RST      = 16'h0000;
	localparam int unsigned PRSR_LATENCY      = 1;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic [7:0]  opcode;
		logic [2:0]  slot;
		logic        has_guard;
		logic [31:0] guard;
		logic [31:0] first_source;
		logic [31:0] second_source;
		logic [6:0]  dest;
	} prsr_issue_t;

	typedef struct packed {
		logic        wr_en;
		logic [6:0]  dest;
		logic [31:0] data;
	} prsr_result_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] target;
		logic        nmi_pending;
		logic        int_pending;
		logic        exception_event;
	} prsr_jump_t;

endpackage : prsr_pkg

/* hdl/prsr_rotator.sv */
// Combinational left rotator used by the shifter path.
`timescale 1ns/1ps
`default_nettype none
module prsr_rotator #(
	parameter int unsigned W     = 32,
	parameter int unsigned AMT_W = 5
) (
	input  wire logic [W-1:0]     value_in,
	input  wire logic [AMT_W-1:0] amount_in,
	output logic      [W-1:0]     rotated_out
);

	// ----------------------------------------------------------------
	// Rotate by shifting a doubled copy
	// ----------------------------------------------------------------
	// Shifting the doubled word avoids a W-n shift that is a full W-bit shift at n=0.
	logic [2*W-1:0] doubled_w;
	assign doubled_w   = {value_in, value_in} << amount_in;
	assign rotated_out = doubled_w[2*W-1:W];

endmodule : prsr_rotator
`default_nettype wire

/* tb/prsr_regfile_model.sv */
// Register file model that stands behind the unit's result port.
`timescale 1ns/1ps
`default_nettype none
module prsr_regfile_model
	import prsr_pkg::*;
(
	input  wire logic         sys_clk_in,
	input  wire logic         rst_n_in,
	input  wire prsr_result_t result_in,
	input  wire logic [6:0]   rd_addr_in,
	output logic      [31:0]  rd_data_out
);
	logic [31:0] regs_r [128];

	// ----------------------------------------------------------------
	// Write port
	// ----------------------------------------------------------------
	// Registers leave reset holding a pattern, not zero, so a lost write cannot look like a result.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < 128; i++) begin
				regs_r[i] <= 32'h5a5a0000 | 32'(i);
			end
		end else if (result_in.wr_en) begin
			regs_r[result_in.dest] <= result_in.data;
		end
	end

	// Read port for the bench is combinational.
	assign rd_data_out = regs_r[rd_addr_in];
endmodule : prsr_regfile_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the status read and rotate unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import prsr_pkg::*;
;
	logic         sys_clk_in = 1'b0;
	logic         rst_n_in   = 1'b0;
	prsr_issue_t  issue_in;
	prsr_jump_t   jump_in;
	logic         mode_load_in;
	logic [15:0]  mode_value_in;
	logic [15:0]  event_set_in;
	logic [15:0]  event_clr_in;
	prsr_result_t result_out;
	logic         illegal_slot_out;
	logic [31:0]  destination_program_counter;
	logic [31:0]  source_program_counter;
	logic [31:0]  csw;
	logic [6:0]   rd_addr;
	logic [31:0]  rd_data;
	logic         exp_ill   = 1'b0;
	int           bad_count = 0;
	int           n_checks  = 0;
	int           cycles    = 0;

	// ----------------------------------------------------------------
	// Design, partner and clock
	// ----------------------------------------------------------------
	prsr_core prsr_core_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .issue_in(issue_in),
		.jump_in(jump_in), .mode_load_in(mode_load_in), .mode_value_in(mode_value_in),
		.event_set_in(event_set_in), .event_clr_in(event_clr_in), .result_out(result_out),
		.illegal_slot_out(illegal_slot_out), .destination_program_counter_out(destination_program_counter),
		.source_program_counter_out(source_program_counter), .control_status_word_out(csw));
	prsr_regfile_model prsr_regfile_model_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.result_in(result_out), .rd_addr_in(rd_addr), .rd_data_out(rd_data));

	always #2.5 sys_clk_in = ~sys_clk_in;

	// A hang is cut short well past the fifty or so cycles the scenarios need.
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		if (bad_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Issues one operation, checks the write strobe and slot flag one cycle on, then the
	// register it hit; every input change stays on a falling edge.
	task automatic do_op(input logic [7:0] op, input logic [2:0] slot, input logic has_g,
			input logic [31:0] g, input logic [31:0] a, input logic [31:0] b,
			input logic [6:0] dst, input logic exp_wr, input logic [31:0] exp_d);
		issue_in = '{valid: 1'b1, opcode: op, slot: slot, has_guard: has_g, guard: g,
			first_source: a, second_source: b, dest: dst};
		@(negedge sys_clk_in);
		issue_in.valid = 1'b0;
		rd_addr = dst;
		chk({31'h0, result_out.wr_en}, {31'h0, exp_wr});
		chk({31'h0, illegal_slot_out}, {31'h0, exp_ill});
		@(negedge sys_clk_in);
		chk(rd_data, exp_d);
	endtask : do_op

	task automatic do_jump(input logic [31:0] t, input logic [2:0] p);
		jump_in = '{valid: 1'b1, target: t, nmi_pending: p[2], int_pending: p[1],
			exception_event: p[0]};
		@(negedge sys_clk_in);
		jump_in.valid = 1'b0;
		// One idle cycle keeps the next call from raising valid in this same time step.
		@(negedge sys_clk_in);
	endtask : do_jump

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_rotate();
		logic [31:0] a_tab [5] = '{32'h20, 32'hfffffffc, 32'he, 32'h12345678, 32'h80000001};
		logic [31:0] b_tab [5] = '{32'h3, 32'h2, 32'hfffffffe, 32'h20, 32'h1f};
		logic [31:0] e_tab [5] = '{32'h100, 32'hfffffff3, 32'h80000003, 32'h12345678, 32'hc0000000};
		for (int i = 0; i < 5; i++) begin
			do_op(PRSR_OP_ROL, (i % 2) ? PRSR_SLOT_SHB : PRSR_SLOT_SHA, 1'b0, 32'h0, a_tab[i],
				b_tab[i], 7'(10 + i), 1'b1, e_tab[i]);
		end
	endtask : t_rotate

	// Interrupted jumps move the destination counter but must leave the source counter alone.
	task automatic t_jump();
		do_jump(32'hbeebee, 3'h0);
		chk(source_program_counter, 32'hbeebee);
		for (int k = 0; k < 3; k++) begin
			do_jump(32'habba + 32'(k), 3'h1 << k);
			chk(destination_program_counter, 32'habba + 32'(k));
			chk(source_program_counter, 32'hbeebee);
		end
		do_op(PRSR_OP_RD_DPC, PRSR_SLOT_CMP, 1'b0, 0, 0, 0, 7'd20, 1'b1, 32'habbc);
		do_op(PRSR_OP_RD_SPC, PRSR_SLOT_CMP, 1'b0, 0, 0, 0, 7'd21, 1'b1, 32'hbeebee);
	endtask : t_jump

	task automatic t_status();
		mode_load_in = 1'b1;
		mode_value_in = 16'h8011;
		event_set_in = 16'h0642;
		@(negedge sys_clk_in);
		mode_load_in = 1'b0;
		event_set_in = 16'h0;
		chk(csw, 32'h80110642);
		do_op(PRSR_OP_RD_CSW, PRSR_SLOT_CMP, 1'b0, 0, 0, 0, 7'd22, 1'b1, 32'h80110642);
		// Bit 1 is cleared while bit 0 sees a set and a clear together; the set must win.
		event_clr_in = 16'h0003;
		event_set_in = 16'h0001;
		@(negedge sys_clk_in);
		event_clr_in = 16'h0;
		event_set_in = 16'h0;
		chk(csw, 32'h80110641);
	endtask : t_status

	// Only guard bit 0 counts; a wrong slot must not write either.
	task automatic t_guard();
		do_op(PRSR_OP_RD_DPC, PRSR_SLOT_CMP, 1'b1, 32'hfffffffe, 0, 0, 7'd30, 1'b0,
			32'h5a5a001e);
		do_op(PRSR_OP_RD_DPC, PRSR_SLOT_CMP, 1'b1, 32'h1, 0, 0, 7'd30, 1'b1, 32'habbc);
		do_op(PRSR_OP_ROL, PRSR_SLOT_SHA, 1'b1, 32'h0, 32'h20, 32'h3, 7'd31, 1'b0,
			32'h5a5a001f);
		exp_ill = 1'b1;
		do_op(PRSR_OP_RD_CSW, PRSR_SLOT_SHA, 1'b0, 0, 0, 0, 7'd32, 1'b0, 32'h5a5a0020);
		do_op(PRSR_OP_ROL, PRSR_SLOT_CMP, 1'b0, 0, 32'h20, 32'h3, 7'd33, 1'b0,
			32'h5a5a0021);
		exp_ill = 1'b0;
	endtask : t_guard

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		issue_in = '0;
		jump_in = '0;
		mode_load_in = 1'b0;
		mode_value_in = 16'h0;
		event_set_in = 16'h0;
		event_clr_in = 16'h0;
		rd_addr = 7'h0;
		repeat (12) @(negedge sys_clk_in);
		rst_n_in = 1'b1;
		@(negedge sys_clk_in);
		chk(destination_program_counter, PRSR_DPC_RST);
		t_rotate();
		t_jump();
		t_status();
		t_guard();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
